// file: sim/drive_config_params_asserts.sv
/*
  Checker for the parameter bank: access answers, refusals, mode apply
  and thermal enable. Assumes it is bound to the top module's ports.
*/
`timescale 1ns/1ps
`include "drive_cfg_defines.vh"
module drive_config_params_asserts (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_acc_req,
    input wire logic        i_acc_src,
    input wire logic        i_acc_wr,
    input wire logic [15:0] i_acc_id,
    input wire logic        o_acc_ack,
    input wire logic        o_acc_refused,
    input wire logic [31:0] o_acc_rdata,
    input wire logic [1:0]  o_mode,
    input wire logic        o_load_defaults,
    input wire logic        o_nv_save,
    input wire logic        o_keypad_status_only,
    input wire logic [15:0] o_therm_const,
    input wire logic        o_therm_prot_en
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // A taken request is the first step of every answer.
    sequence s_taken;
        i_ce && i_acc_req;
    endsequence
    // Both pulses of a mode apply land together.
    sequence s_defaults;
        o_load_defaults && o_nv_save;
    endsequence
    a_ack_after_req:  assert property (s_taken |=> o_acc_ack) else $error("ack missing");
    a_no_stray_ack:   assert property (o_acc_ack |-> $past(i_acc_req)) else $error("stray ack");
    a_refuse_has_ack: assert property (o_acc_refused |-> o_acc_ack) else $error("refuse no ack");
    a_refuse_zero:    assert property (o_acc_refused |-> o_acc_rdata == 32'h0)
        else $error("refused data");
    a_fw_write_ro:    assert property (
        s_taken ##0 (i_acc_wr && i_acc_id == `ID_FW) |=> o_acc_refused)
        else $error("fw written");
    a_status_blind:   assert property (
        s_taken ##0 (o_keypad_status_only && !i_acc_src && !i_acc_wr) |=> o_acc_refused)
        else $error("status view read");
    a_mode_legal:     assert property (o_mode != 2'h0) else $error("mode zero");
    a_mode_apply:     assert property ($changed(o_mode) |-> s_defaults)
        else $error("no defaults");
    a_therm_prot:     assert property (
        o_therm_prot_en == ($past(o_therm_const) != 16'h0))
        else $error("prot enable");
endmodule // drive_config_params_asserts

// file: sim/drive_config_params_tb.sv
/*
  Self-checking bench for the parameter bank through its access port.
  Assumes the bank's defines header is on the include path.
*/
`timescale 1ns/1ps
`include "drive_cfg_defines.vh"
module drive_config_params_tb;
    // Clock starts high so the first edge is a falling one and reset rises on it.
    logic        i_core_clk = 1'b1, i_rst = 1'b0;
    logic        req, src, wr, ack, refused;
    logic [15:0] id;
    logic [31:0] wdata, rdata, rd;
    logic        ak, rf, dres = 1'b0, minor = 1'b0, phase = 1'b0, topen = 1'b0;
    logic        size35 = 1'b0, running = 1'b0, tclr = 1'b0;
    logic [1:0]  mode;
    logic        ld, nvs, stat, stop, ovl_en, ph_trip, br_trip, frz, prot;
    logic        mtrip, phs;
    logic [15:0] tconst;
    logic [7:0]  s_addr, s_baud;
    int          err_count = 0, checks_done = 0;
    localparam logic [5:0] RD_REF = 6'b110101, WR_REF = 6'b111100;
    initial forever #2 i_core_clk = ~i_core_clk;
    param_host HOST (.i_core_clk(i_core_clk), .i_ack(ack), .i_refused(refused),
        .i_rdata(rdata), .o_req(req), .o_src(src), .o_wr(wr), .o_id(id), .o_wdata(wdata));
    drive_config_params DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_acc_req(req), .i_acc_src(src), .i_acc_wr(wr), .i_acc_id(id),
        .i_acc_wdata(wdata), .o_acc_ack(ack), .o_acc_refused(refused), .o_acc_rdata(rdata),
        .i_drive_reset(dres), .i_minor_trip(minor), .i_brake_overload(1'b0),
        .i_phase_loss(phase), .i_brake_therm_open(topen), .i_size_3to5(size35),
        .i_running(running), .i_trip_clear(tclr), .o_mode(mode), .o_load_defaults(ld),
        .o_nv_save(nvs), .o_keypad_status_only(stat), .o_stop_req(stop),
        .o_minor_trip(mtrip),
        .o_brake_ovl_det_en(ovl_en), .o_phase_stop(phs), .o_phase_trip(ph_trip),
        .o_brake_therm_trip(br_trip), .o_monitor_freeze(frz), .o_therm_const(tconst),
        .o_therm_prot_en(prot), .o_serial_addr(s_addr), .o_serial_mode(),
        .o_serial_baud(s_baud), .o_serial_tx_delay(), .o_serial_silent());
    task chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One access with its answer checked; read data only matters on reads.
    task op(input logic s, w, input logic [15:0] i, input logic [31:0] wd,
            input logic eref, input logic [31:0] erd);
        HOST.xfer(s, w, i, wd, ak, rf, rd);
        chk(ak, 1'b1);
        chk(rf, eref);
        if (!w) chk(rd, erd);
    endtask
    task waitn(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog sized well past the roughly 150 cycles the tests take.
    initial begin
        #100000;
        err_count++;
        close_out;
    end
    initial begin
        // A real rising edge on reset is needed; an initialiser makes no event.
        @(negedge i_core_clk);
        i_rst = 1'b1;
        waitn(4);
        i_rst = 1'b0;
        chk(mode, 2'h1);
        chk(prot, 1'b1);
        op(1, 0, `ID_TRIP, 0, 0, 0);
        op(1, 0, `ID_THERM, 0, 0, 32'h37a);
        op(1, 0, `ID_FW, 0, 0, 32'h1);
        op(1, 1, `ID_FW, 32'h5, 1, 0);
        op(1, 1, `ID_MODE, 32'h2, 1, 0);
        HOST.unlock(ak, rf, rd);
        chk(rf, 1'b0);
        op(1, 1, `ID_MODE, 32'h0, 1, 0);
        op(1, 1, `ID_MODE, 32'h3, 0, 0);
        op(1, 0, `ID_MODE, 0, 0, 32'h3);
        dres = 1'b1;
        waitn(6);
        dres = 1'b0;
        chk(mode, 2'h3);
        // Level sweep: keypad level writes always land, then probe each path.
        for (int lv = 0; lv < 6; lv++) begin
            op(0, 1, `ID_SEC, lv, 0, 0);
            waitn(1);
            chk(stat, lv >= 4);
            op(0, 0, `ID_TRIP, 0, RD_REF[lv], 0);
            op(0, 1, `ID_TRIP, 0, WR_REF[lv], 0);
            op(1, 0, `ID_TRIP, 0, lv == 5, 0);
        end
        op(0, 1, `ID_SEC, 32'h1, 0, 0);
        op(1, 1, `ID_SEC, 32'h6, 1, 0);
        op(1, 0, `ID_SEC, 0, 0, 32'h1);
        // Trip actions: options steer the trip outputs from the pins.
        op(1, 1, `ID_TRIP, 32'h1, 0, 0);
        running = 1'b1; minor = 1'b1;
        waitn(5);
        chk(stop, 1'b1);
        chk(mtrip, 1'b0);
        running = 1'b0;
        waitn(5);
        chk(mtrip, 1'b1);
        chk(stop, 1'b0);
        minor = 1'b0; running = 1'b1;
        op(1, 1, `ID_TRIP, 32'h4, 0, 0);
        phase = 1'b1;
        waitn(5);
        chk(ph_trip, 1'b0);
        chk(phs, 1'b0);
        running = 1'b0;
        waitn(5);
        chk(ph_trip, 1'b1);
        chk(frz, 1'b1);
        size35 = 1'b1; topen = 1'b1;
        op(1, 1, `ID_TRIP, 32'ha, 0, 0);
        waitn(5);
        chk(ovl_en, 1'b0);
        chk(br_trip, 1'b0);
        chk(phs, 1'b1);
        chk(ph_trip, 1'b0);
        chk(frz, 1'b1);
        tclr = 1'b1;
        waitn(5);
        chk(frz, 1'b0);
        tclr = 1'b0; phase = 1'b0;
        op(1, 1, `ID_TRIP, 32'h0, 0, 0);
        waitn(5);
        chk(br_trip, 1'b1);
        chk(ovl_en, 1'b1);
        // Serial settings stay staged until the reload bit is written.
        op(1, 1, `ID_SER_FIRST, 32'h22, 0, 0);
        op(1, 1, 16'h0b19, 32'h96, 0, 0);
        op(1, 0, 16'h0b19, 0, 0, 32'h96);
        chk(s_addr, 8'h01);
        chk(s_baud, 8'h00);
        op(1, 1, `ID_RELOAD, 32'h1, 0, 0);
        waitn(2);
        chk(s_addr, 8'h22);
        chk(s_baud, 8'h96);
        op(1, 0, `ID_RELOAD, 0, 0, 0);
        op(1, 1, `ID_THERM, 32'h0, 0, 0);
        waitn(2);
        chk(prot, 1'b0);
        close_out;
    end
endmodule // drive_config_params_tb

bind drive_config_params drive_config_params_asserts CHK (.i_core_clk, .i_rst, .i_ce,
    .i_acc_req, .i_acc_src, .i_acc_wr, .i_acc_id, .o_acc_ack, .o_acc_refused,
    .o_acc_rdata, .o_mode, .o_load_defaults, .o_nv_save, .o_keypad_status_only,
    .o_therm_const, .o_therm_prot_en);

// file: sim/param_host.sv
/*
  Behavioural keypad and comms host driving the parameter access port.
  Assumes the bank answers one cycle after each request pulse.
*/
`timescale 1ns/1ps
module param_host (
    input  wire logic        i_core_clk,
    input  wire logic        i_ack,
    input  wire logic        i_refused,
    input  wire logic [31:0] i_rdata,
    output logic             o_req,
    output logic             o_src,
    output logic             o_wr,
    output logic [15:0]      o_id,
    output logic [31:0]      o_wdata
);
    initial begin
        o_req = 1'b0; o_src = 1'b0; o_wr = 1'b0; o_id = 16'h0; o_wdata = 32'h0;
    end
    // One pulse, then the id and write data lines are inverted so stale values never match.
    task xfer(input logic s, w, input logic [15:0] id, input logic [31:0] wd,
              output logic ak, rf, output logic [31:0] rd);
        @(negedge i_core_clk);
        o_req = 1'b1; o_src = s; o_wr = w; o_id = id; o_wdata = wd;
        @(negedge i_core_clk);
        o_req = 1'b0; o_id = ~id; o_wdata = ~wd;
        ak = i_ack; rf = i_refused; rd = i_rdata;
    endtask
    // The code must be loaded before a mode change is attempted.
    task unlock(output logic ak, rf, output logic [31:0] rd);
        xfer(1'b1, 1'b1, 16'h0b00, 32'h4e5, ak, rf, rd);
    endtask
endmodule // param_host

// file: verilog/drive_cfg_defines.vh
/*
  Constants for the drive configuration parameter bank: parameter
  identifiers, encodings, reset values and access levels.
  Assumes it is included by its bare name from the design file.
*/
`ifndef DRIVE_CFG_DEFINES_VH
`define DRIVE_CFG_DEFINES_VH

// Parameter identifiers are {menu, parameter}, both as binary numbers.
`define ID_MODE        16'h0b1f
`define ID_SEC         16'h0b2c
`define ID_FW          16'h0b1d
`define ID_TRIP        16'h0a25
`define ID_RELOAD      16'h0b14
`define ID_THERM       16'h040f
`define ID_SER_FIRST   16'h0b17
`define ID_SER_LAST    16'h0b1b
`define ID_M0_MODE     16'h0030
`define ID_M0_SEC      16'h0031
`define ID_M0_FW       16'h0032
`define ID_M0_TRIP     16'h0033
`define ID_M0_RELOAD   16'h0034
`define ID_M0_THERM    16'h0035
`define ID_UNLOCK_LO   8'h00

// Decoded parameter selects.
`define SEL_NONE       4'h0
`define SEL_UNLOCK     4'h1
`define SEL_MODE       4'h2
`define SEL_SEC        4'h3
`define SEL_FW         4'h4
`define SEL_TRIP       4'h5
`define SEL_RELOAD     4'h6
`define SEL_THERM      4'h7
`define SEL_SER        4'h8

// Operating modes and unlock codes (1253 and 1254).
`define MODE_OPEN_LOOP 2'h1
`define MODE_IND_VEC   2'h2
`define MODE_MAG_VEC   2'h3
`define UNLOCK_EU      16'h04e5
`define UNLOCK_US      16'h04e6

// Security levels.
`define SEC_MENU0      3'h0
`define SEC_ALL        3'h1
`define SEC_RO_MENU0   3'h2
`define SEC_RO_ALL     3'h3
`define SEC_STATUS     3'h4
`define SEC_NO_ACCESS  3'h5

// Trip-action bit positions and reset values.
`define TA_STOP        0
`define TA_NO_BR_OVL   1
`define TA_NO_PH_STOP  2
`define TA_NO_BR_THERM 3
`define TA_NO_FREEZE   4
`define TRIP_RST       5'h00
`define THERM_RST      16'h037a
`define SER_ADDR_RST   8'h01
`define SER_RST        8'h00
`define SRC_COMMS      1'h1

`endif

// file: verilog/drive_config_params.v
/*
  Configuration and status parameter bank of a motor drive: mode select
  with unlock, keypad and comms security, firmware version, trip actions,
  staged serial settings and the motor thermal time constant.
  Assumes one access port shared by keypad and comms logic on the same
  clock, and drive pins that are asynchronous and get synchronised here.
*/
`timescale 1ns/1ps
`include "drive_cfg_defines.vh"

module drive_config_params #(
    parameter [31:0] FW_VERSION = 32'h0000_0001  // Arbitrary value.
) (
    // Clock, reset, enable.
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_ce,
    // Parameter access port.
    input  wire        i_acc_req,
    input  wire        i_acc_src,
    input  wire        i_acc_wr,
    input  wire [15:0] i_acc_id,
    input  wire [31:0] i_acc_wdata,
    output reg         o_acc_ack,
    output reg         o_acc_refused,
    output reg  [31:0] o_acc_rdata,
    // Drive pins.
    input  wire        i_drive_reset,
    input  wire        i_minor_trip,
    input  wire        i_brake_overload,
    input  wire        i_phase_loss,
    input  wire        i_brake_therm_open,
    input  wire        i_size_3to5,
    input  wire        i_running,
    input  wire        i_trip_clear,
    // Mode and defaults.
    output reg  [1:0]  o_mode,
    output reg         o_load_defaults,
    output reg         o_nv_save,
    // Keypad view state.
    output reg         o_keypad_status_only,
    // Trip handling.
    output reg         o_stop_req,
    output reg         o_minor_trip,
    output reg         o_brake_ovl_det_en,
    output reg         o_phase_stop,
    output reg         o_phase_trip,
    output reg         o_brake_therm_trip,
    output reg         o_monitor_freeze,
    // Thermal model.
    output reg  [15:0] o_therm_const,
    output reg         o_therm_prot_en,
    // Active serial settings.
    output wire [7:0]  o_serial_addr,
    output wire [7:0]  o_serial_mode,
    output wire [7:0]  o_serial_baud,
    output wire [7:0]  o_serial_tx_delay,
    output wire [7:0]  o_serial_silent
);

    // Maps a parameter identifier, menu zero aliases included, to a select.
    function [3:0] decode;
        input [15:0] id;
        begin
            if (id[7:0] == `ID_UNLOCK_LO)
                decode = `SEL_UNLOCK;
            else if (id == `ID_MODE || id == `ID_M0_MODE)
                decode = `SEL_MODE;
            else if (id == `ID_SEC || id == `ID_M0_SEC)
                decode = `SEL_SEC;
            else if (id == `ID_FW || id == `ID_M0_FW)
                decode = `SEL_FW;
            else if (id == `ID_TRIP || id == `ID_M0_TRIP)
                decode = `SEL_TRIP;
            else if (id == `ID_RELOAD || id == `ID_M0_RELOAD)
                decode = `SEL_RELOAD;
            else if (id == `ID_THERM || id == `ID_M0_THERM)
                decode = `SEL_THERM;
            else if (id >= `ID_SER_FIRST && id <= `ID_SER_LAST)
                decode = `SEL_SER;
            else
                decode = `SEL_NONE;
        end
    endfunction

    // Access permission by security level, source and menu.
    function permit;
        input [2:0] lvl;
        input       comms;
        input       wr;
        input       menu0;
        input       is_sec;
        begin
            if (comms)
                permit = (lvl != `SEC_NO_ACCESS);
            // Only the level write is exempt; a status-only keypad views nothing.
            else if (is_sec && wr)
                permit = 1'b1;
            else begin
                case (lvl)
                    `SEC_MENU0:    permit = wr | menu0;
                    `SEC_ALL:      permit = 1'b1;
                    `SEC_RO_MENU0: permit = ~wr & menu0;
                    `SEC_RO_ALL:   permit = ~wr;
                    default:       permit = 1'b0;
                endcase
            end
        end
    endfunction

    // Pin synchroniser; stage one feeds stage two only.
    wire [7:0] pins = {i_trip_clear, i_running, i_size_3to5, i_brake_therm_open,
                       i_phase_loss, i_brake_overload, i_minor_trip, i_drive_reset};
    reg  [7:0] sync1;
    reg  [7:0] sync2;
    reg        drst_prev;
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1     <= 8'h00;
            sync2     <= 8'h00;
            drst_prev <= 1'b0;
        end else if (i_ce) begin
            sync1     <= pins;
            sync2     <= sync1;
            drst_prev <= sync2[0];
        end
    end

    wire s_drst     = sync2[0];
    wire s_minor    = sync2[1];
    wire s_br_ovl   = sync2[2];
    wire s_phase    = sync2[3];
    wire s_th_open  = sync2[4];
    wire s_size35   = sync2[5];
    wire s_running  = sync2[6];
    wire s_clear    = sync2[7];

    // Parameter storage.
    reg [15:0] unlock;
    reg [1:0]  mode_sel;
    reg [2:0]  sec;
    reg [4:0]  trip_act;
    reg        reload;
    reg [7:0]  ser_stage [0:4];
    reg [7:0]  ser_active [0:4];
    reg        phase_pend;
    reg        minor_pend;
    reg        tripped;

    // Access decode and validation.
    wire [3:0] sel    = decode(i_acc_id);
    wire [15:0] ser_off = i_acc_id - `ID_SER_FIRST;
    wire [2:0]  ser_ix  = ser_off[2:0];
    wire       ok     = (sel != `SEL_NONE) &
                        permit(sec, i_acc_src == `SRC_COMMS, i_acc_wr,
                               i_acc_id[15:8] == 8'h00, sel == `SEL_SEC);
    wire       unlocked = (unlock == `UNLOCK_EU) | (unlock == `UNLOCK_US);
    reg        wr_ok;
    reg [31:0] next_rdata;

    // Value checks on writes; the firmware version never takes one.
    always @* begin
        case (sel)
            `SEL_MODE: wr_ok = unlocked & (i_acc_wdata[31:2] == 30'h0) &
                               (i_acc_wdata[1:0] != 2'h0);
            `SEL_SEC:  wr_ok = i_acc_wdata <= {29'h0, `SEC_NO_ACCESS};
            `SEL_FW:   wr_ok = 1'b0;
            `SEL_NONE: wr_ok = 1'b0;
            default:   wr_ok = 1'b1;
        endcase
    end

    // Read mux, narrower parameters sit in the low bits.
    always @* begin
        case (sel)
            `SEL_UNLOCK: next_rdata = {16'h0, unlock};
            `SEL_MODE:   next_rdata = {30'h0, mode_sel};
            `SEL_SEC:    next_rdata = {29'h0, sec};
            `SEL_FW:     next_rdata = FW_VERSION;
            `SEL_TRIP:   next_rdata = {27'h0, trip_act};
            `SEL_RELOAD: next_rdata = {31'h0, reload};
            `SEL_THERM:  next_rdata = {16'h0, o_therm_const};
            `SEL_SER:    next_rdata = {24'h0, ser_stage[ser_ix]};
            default:     next_rdata = 32'h0;
        endcase
    end

    wire do_wr = i_acc_req & i_acc_wr & ok & wr_ok;

    // Access answer is registered one cycle after the request.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_acc_ack     <= 1'b0;
            o_acc_refused <= 1'b0;
            o_acc_rdata   <= 32'h0;
        end else if (i_ce) begin
            o_acc_ack     <= i_acc_req;
            o_acc_refused <= i_acc_req & ~(ok & (~i_acc_wr | wr_ok));
            o_acc_rdata   <= (i_acc_req & ok & ~i_acc_wr) ? next_rdata : 32'h0;
        end
    end

    // Parameter writes, mode application and serial reload.
    integer k;
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            unlock          <= 16'h0;
            mode_sel        <= `MODE_OPEN_LOOP;
            o_mode          <= `MODE_OPEN_LOOP;
            sec             <= `SEC_MENU0;
            trip_act        <= `TRIP_RST;
            reload          <= 1'b0;
            o_therm_const   <= `THERM_RST;
            o_load_defaults <= 1'b0;
            o_nv_save       <= 1'b0;
            for (k = 0; k < 5; k = k + 1) begin
                ser_stage[k]  <= (k == 0) ? `SER_ADDR_RST : `SER_RST;
                ser_active[k] <= (k == 0) ? `SER_ADDR_RST : `SER_RST;
            end
        end else if (i_ce) begin
            o_load_defaults <= 1'b0;
            o_nv_save       <= 1'b0;
            if (do_wr) begin
                case (sel)
                    `SEL_UNLOCK: unlock <= i_acc_wdata[15:0];
                    `SEL_MODE:   mode_sel <= i_acc_wdata[1:0];
                    `SEL_SEC:    sec <= i_acc_wdata[2:0];
                    `SEL_TRIP:   trip_act <= i_acc_wdata[4:0];
                    `SEL_THERM:  o_therm_const <= i_acc_wdata[15:0];
                    `SEL_SER:    ser_stage[ser_ix] <= i_acc_wdata[7:0];
                    default:     ;
                endcase
            end
            // A new request wins over the self-clear in the same cycle.
            if (do_wr && sel == `SEL_RELOAD && i_acc_wdata[0]) begin
                reload <= 1'b1;
            end else if (reload) begin
                for (k = 0; k < 5; k = k + 1)
                    ser_active[k] <= ser_stage[k];
                reload <= 1'b0;
            end
            // Only a changed mode reloads defaults, so plain resets are cheap.
            if (s_drst && !drst_prev && mode_sel != o_mode) begin
                o_mode          <= mode_sel;
                o_load_defaults <= 1'b1;
                o_nv_save       <= 1'b1;
            end
        end
    end

    assign o_serial_addr     = ser_active[0];
    assign o_serial_mode     = ser_active[1];
    assign o_serial_baud     = ser_active[2];
    assign o_serial_tx_delay = ser_active[3];
    assign o_serial_silent   = ser_active[4];

    wire next_tripped = o_minor_trip | o_phase_trip | o_brake_therm_trip;

    // Trip actions; deferred trips wait for the drive to come to rest.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stop_req           <= 1'b0;
            o_minor_trip         <= 1'b0;
            o_brake_ovl_det_en   <= 1'b1;
            o_phase_stop         <= 1'b0;
            o_phase_trip         <= 1'b0;
            o_brake_therm_trip   <= 1'b0;
            o_monitor_freeze     <= 1'b0;
            o_therm_prot_en      <= 1'b1;
            o_keypad_status_only <= 1'b0;
            phase_pend           <= 1'b0;
            minor_pend           <= 1'b0;
            tripped              <= 1'b0;
        end else if (i_ce) begin
            minor_pend <= trip_act[`TA_STOP] & (minor_pend | s_minor) & s_running;
            o_stop_req <= trip_act[`TA_STOP] & (minor_pend | s_minor) & s_running;
            o_minor_trip <= s_minor & (~trip_act[`TA_STOP] | ~s_running);
            o_brake_ovl_det_en <= ~trip_act[`TA_NO_BR_OVL];
            o_phase_stop <= s_phase & ~trip_act[`TA_NO_PH_STOP];
            phase_pend   <= trip_act[`TA_NO_PH_STOP] & (phase_pend | s_phase) & s_running;
            o_phase_trip <= trip_act[`TA_NO_PH_STOP] & (phase_pend | s_phase)
                            & ~s_running;
            o_brake_therm_trip <= s_size35 & s_th_open
                                  & ~trip_act[`TA_NO_BR_THERM];
            // A new trip wins over a clear arriving in the same cycle.
            tripped <= next_tripped | (tripped & ~s_clear);
            o_monitor_freeze <= (next_tripped | (tripped & ~s_clear))
                                & ~trip_act[`TA_NO_FREEZE];
            o_therm_prot_en <= (o_therm_const != 16'h0);
            o_keypad_status_only <= (sec >= `SEC_STATUS);
        end
    end

endmodule // drive_config_params
